// ---- hw/acd_pkg.sv ----
// acd_pkg: constants and types of the ata command decoder
package acd_pkg;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_PWR_A  = 8'hE5;
  localparam logic [7:0] CMD_PWR_B  = 8'h98;
  localparam logic [7:0] CMD_DIAG   = 8'h90;
  localparam logic [7:0] CMD_ERASE  = 8'hC0;
  localparam logic [7:0] CMD_FMT    = 8'h50;
  localparam logic [7:0] CMD_IDENT  = 8'hEC;
  localparam logic [7:0] CMD_IDLE_A = 8'hE3;
  localparam logic [7:0] CMD_IDLE_B = 8'h97;
  localparam logic [7:0] CMD_IIMM_A = 8'hE1;
  localparam logic [7:0] CMD_IIMM_B = 8'h95;
  localparam logic [7:0] CMD_INIT   = 8'h91;
  localparam logic [7:0] CMD_RDBUF  = 8'hE4;
  localparam logic [7:0] CMD_RDMUL  = 8'hC4;
  localparam logic [7:0] CMD_RDL_A  = 8'h22;
  localparam logic [7:0] CMD_RDL_B  = 8'h23;
  localparam logic [7:0] CMD_SETMUL = 8'hC6;
  // ----------------------------------------
  // result codes and reset values
  // ----------------------------------------
  localparam logic [7:0]  ERR_ABORT   = 8'h04; // aborted command
  localparam logic [7:0]  DIAG_PASS   = 8'h01; // diagnostic passed
  localparam logic [7:0]  PWR_ACTIVE  = 8'hFF; // power query: active
  localparam logic [7:0]  PWR_IDLE    = 8'h80; // power query: idle
  localparam logic [7:0]  BLK_RST     = 8'h01; // multiple block size
  localparam logic [7:0]  SPT_RST     = 8'h20; // sectors per track
  localparam logic [3:0]  HPC_RST     = 4'hF;  // heads per cylinder - 1
  localparam logic [31:0] CARD_SECS   = 32'h0003_D200; // total sectors
  localparam logic [15:0] FILL_PAT    = 16'hFFFF;      // format pattern
  // ----------------------------------------
  // identification words
  // ----------------------------------------
  localparam logic [15:0] ID_W0  = 16'h848A;
  localparam logic [15:0] ID_W22 = 16'h0004;
  localparam logic [15:0] ID_W47 = 16'h0001;
  localparam logic [15:0] ID_W49 = 16'h0E00;
  localparam logic [15:0] ID_W51 = 16'h0200;
  localparam logic [15:0] ID_W53 = 16'h0003;
  localparam logic [15:0] ID_W59 = 16'h0101;
  localparam logic [15:0] ID_W64 = 16'h0003;
  // ----------------------------------------
  // transfer sizes and timing
  // ----------------------------------------
  localparam logic [8:0] WORDS_STD  = 9'h100; // 512 bytes
  localparam logic [8:0] WORDS_LONG = 9'h102; // 516 bytes
  localparam int CLK_MHZ   = 250;
  localparam int BUSY_NS   = 20;   // busy phase of a command
  localparam int DIAG_NS   = 400;  // self test duration
  localparam logic [7:0] BUSY_CYC = 8'((BUSY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] DIAG_CYC = 8'((DIAG_NS * CLK_MHZ + 999) / 1000);
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  feature_operand;
    logic [7:0]  count_operand;
    logic [7:0]  sector_index_operand;
    logic [15:0] cylinder_operand;
    logic        drive_select_bit;
    logic [3:0]  head_operand;
  } acd_operand_t;
  typedef struct packed {
    logic        fill;  // one-cycle fill request
    logic [15:0] cyl;
    logic [3:0]  head;
    logic [15:0] pattern;
  } acd_fill_t;
  typedef enum logic [3:0] {
    OP_PWR, OP_DIAG, OP_NOP, OP_FMT, OP_FILL, OP_ID, OP_IDLE, OP_INIT,
    OP_RDBUF, OP_RDMUL, OP_RDLONG, OP_SETMUL, OP_ABORT
  } acd_op_t;
endpackage

// ---- hw/acd_decoder.sv ----
// acd_decoder: command decoder and executor of the task-file card
//
// Function
// R1 - E5h/98h report power state
// R2 - 90h runs self diagnostic, reports result
// R3 - C0h accepted, stored data untouched
// R4 - 50h takes one sector, fills track
// R5 - ECh presents 256-word identification block
// R6 - id word 0 reads 848Ah
// R7 - id word 49 reads 0E00h
// R8 - id word 47 reads 0001h
// R9 - id word 64 reads 0003h
// R10 - id word 22 reads 0004h
// R11 - id word 51 reads 0200h
// R12 - id word 53 reads 0003h
// R13 - id word 59 reads 0101h
// R14 - id words 7-8 hold sector total
// R15 - any 8-bit count accepted
// R16 - E3h/97h busy, idle, ready, interrupt
// R17 - idle count nonzero enables auto power-down
// R18 - E1h/95h busy, idle, ready, interrupt
// R19 - 91h sets sectors and heads geometry
// R20 - E4h reads out sector buffer
// R21 - C4h interrupts once per block; code also interrupts after the last sector
// R22 - 22h/23h read 516 bytes per sector
// R23 - busy high while operation runs
// R24 - interrupt line only when mask clear
// R25 - count zero means 256 sectors
// R26 - C6h records multiple block size
// R27 - unknown command aborts with error
`timescale 1ns/1ps
module acd_decoder (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 soft_reset,   // task-file reset level
  input  wire logic                 cmd_wr,       // command write pulse
  input  wire logic [7:0]           cmd_code,
  input  wire acd_pkg::acd_operand_t operands,
  input  wire logic                 irq_mask_bit,
  input  wire logic                 status_rd,    // status read pulse
  input  wire logic                 data_rd,      // data word read pulse
  input  wire logic                 data_wr,      // data word write pulse
  input  wire logic [15:0]          data_in,
  output logic [15:0]               data_out,
  output logic                      card_occupied_flag,
  output logic                      transfer_request_flag,
  output logic                      err_flag,
  output logic [7:0]                error_code,
  output logic [7:0]                count_result,
  output logic                      host_irq_line, // active high
  output logic                      auto_pd_en,
  output logic                      idle_mode,
  output logic [7:0]                sectors_per_track,
  output logic [3:0]                heads_last,
  output logic [7:0]                block_size,
  output acd_pkg::acd_fill_t        fill_req
);
  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  typedef enum logic [1:0] {ST_READY, ST_BUSY, ST_OUT, ST_IN} acd_state_t;
  acd_state_t       state;            // sequencer state
  acd_pkg::acd_op_t op;               // command in progress
  logic [7:0]       busy_cnt;         // busy phase countdown
  logic [8:0]       idx;              // word index in sector
  logic [8:0]       secs_left;        // sectors still to move
  logic [7:0]       blk_left;         // sectors left in block
  logic             irq_pending;      // sticky interrupt request
  logic [15:0]      sbuf [0:255];     // sector buffer
  logic             accept;           // command taken this cycle
  logic             sec_end;          // last word of a sector read
  logic             buf_we;           // buffer write strobe
  logic             xfer_set;         // new data block offered
  logic [8:0]       words;            // words per sector of op
  acd_pkg::acd_op_t next_op;          // decoded command

  // identification word lookup
  function automatic logic [15:0] id_word(input logic [8:0] a,
                                          input logic [7:0] spt,
                                          input logic [3:0] hds);
    logic [15:0] w;
    w = 16'h0000;
    unique case (a)
      9'h000:         w = acd_pkg::ID_W0;                // [R6]
      9'h001, 9'h036: w = acd_pkg::CARD_SECS[31:16] == 16'h0000 ?
                          16'(acd_pkg::CARD_SECS[15:0] / 16'(hds + 5'h01)
                          / 16'(spt == 8'h00 ? 9'h100 : 9'(spt)))
                          : 16'h3FFF;
      9'h003, 9'h037: w = 16'(hds) + 16'h0001;
      9'h006, 9'h038: w = 16'(spt);
      9'h007:         w = acd_pkg::CARD_SECS[31:16];     // [R14]
      9'h008:         w = acd_pkg::CARD_SECS[15:0];      // [R14]
      9'h016:         w = acd_pkg::ID_W22;               // [R10]
      9'h02F:         w = acd_pkg::ID_W47;               // [R8]
      9'h031:         w = acd_pkg::ID_W49;               // [R7]
      9'h033:         w = acd_pkg::ID_W51;               // [R11]
      9'h035:         w = acd_pkg::ID_W53;               // [R12]
      9'h03B:         w = acd_pkg::ID_W59;               // [R13]
      9'h03C:         w = acd_pkg::CARD_SECS[15:0];
      9'h03D:         w = acd_pkg::CARD_SECS[31:16];
      9'h040:         w = acd_pkg::ID_W64;               // [R9]
      default:        w = 16'h0000;                      // reserved
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign accept = cmd_wr && (state == ST_READY) && !soft_reset;
  assign words  = (op == acd_pkg::OP_RDLONG) ? acd_pkg::WORDS_LONG
                                             : acd_pkg::WORDS_STD; // [R22]
  assign sec_end = (state == ST_OUT) && data_rd && (idx == words - 9'h001);
  assign buf_we  = (state == ST_IN) && data_wr;
  assign xfer_set = (state == ST_BUSY) && (busy_cnt == 8'h00) &&
                   (op inside {acd_pkg::OP_ID, acd_pkg::OP_RDBUF,
                               acd_pkg::OP_RDMUL, acd_pkg::OP_RDLONG});

  // map command byte onto an operation
  always_comb begin
    unique case (cmd_code)
      acd_pkg::CMD_PWR_A, acd_pkg::CMD_PWR_B:   next_op = acd_pkg::OP_PWR;
      acd_pkg::CMD_DIAG:                        next_op = acd_pkg::OP_DIAG;
      acd_pkg::CMD_ERASE:                       next_op = acd_pkg::OP_NOP;
      acd_pkg::CMD_FMT:                         next_op = acd_pkg::OP_FMT;
      acd_pkg::CMD_IDENT:                       next_op = acd_pkg::OP_ID;
      acd_pkg::CMD_IDLE_A, acd_pkg::CMD_IDLE_B,
      acd_pkg::CMD_IIMM_A, acd_pkg::CMD_IIMM_B: next_op = acd_pkg::OP_IDLE;
      acd_pkg::CMD_INIT:                        next_op = acd_pkg::OP_INIT;
      acd_pkg::CMD_RDBUF:                       next_op = acd_pkg::OP_RDBUF;
      acd_pkg::CMD_RDMUL:                       next_op = acd_pkg::OP_RDMUL;
      acd_pkg::CMD_RDL_A, acd_pkg::CMD_RDL_B:   next_op = acd_pkg::OP_RDLONG;
      acd_pkg::CMD_SETMUL:                      next_op = acd_pkg::OP_SETMUL;
      default:                                  next_op = acd_pkg::OP_ABORT;
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // ready -> busy -> (out | in | ready)
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state     <= ST_READY;
      op        <= acd_pkg::OP_NOP;
      busy_cnt  <= 8'h00;
      idx       <= 9'h000;
      secs_left <= 9'h000;
      blk_left  <= 8'h00;
    end else if (soft_reset) begin
      state     <= ST_READY;
      op        <= acd_pkg::OP_NOP;
      busy_cnt  <= 8'h00;
      idx       <= 9'h000;
      blk_left  <= 8'h00;             // a cut read must not leak its block count
    end else begin
      unique case (state)
        ST_READY: if (accept) begin
          state    <= ST_BUSY;                              // [R23]
          op       <= next_op;
          busy_cnt <= (next_op == acd_pkg::OP_DIAG) ? acd_pkg::DIAG_CYC - 8'h01
                                                    : acd_pkg::BUSY_CYC - 8'h01; // [R2]
          idx      <= 9'h000;
          // count zero asks for 256 sectors; any byte taken
          secs_left <= (operands.count_operand == 8'h00) ? 9'h100
                       : 9'(operands.count_operand);       // [R25] [R15]
          if (next_op != acd_pkg::OP_RDMUL)
            secs_left <= 9'h001;                           // one sector else
        end
        ST_BUSY: if (busy_cnt != 8'h00) begin
          busy_cnt <= busy_cnt - 8'h01;
        end else if (xfer_set) begin
          state    <= ST_OUT;                              // [R5] [R20]
          idx      <= 9'h000;
          if (blk_left == 8'h00)
            blk_left <= block_size;
        end else if (op == acd_pkg::OP_FMT) begin
          state    <= ST_IN;                               // [R4]
          idx      <= 9'h000;
        end else begin
          state    <= ST_READY;
        end
        ST_IN: if (data_wr) begin
          idx <= idx + 9'h001;
          if (idx == acd_pkg::WORDS_STD - 9'h001) begin
            state    <= ST_BUSY;                           // [R4]
            op       <= acd_pkg::OP_FILL;
            busy_cnt <= acd_pkg::BUSY_CYC - 8'h01;
          end
        end
        ST_OUT: if (data_rd) begin
          idx <= sec_end ? 9'h000 : idx + 9'h001;
          if (sec_end) begin
            secs_left <= secs_left - 9'h001;
            blk_left  <= blk_left - 8'h01;
            if (secs_left == 9'h001) begin
              state    <= ST_READY;
              blk_left <= 8'h00;
            end else if (blk_left == 8'h01) begin
              state    <= ST_BUSY;                         // [R21]
              busy_cnt <= acd_pkg::BUSY_CYC - 8'h01;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // sector buffer and data port
  // ----------------------------------------
  // host words land in the buffer; erase never writes it
  always_ff @(posedge mclk) begin
    if (buf_we)
      sbuf[idx[7:0]] <= data_in;                           // [R3]
  end

  // data word for the current index, one cycle behind it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      data_out <= 16'h0000;
    else if (op == acd_pkg::OP_ID)
      data_out <= id_word(idx, sectors_per_track, heads_last); // [R5]
    else if (idx[8])
      data_out <= 16'h0000;                                // ecc words [R22]
    else
      data_out <= sbuf[idx[7:0]];                          // [R20]
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  assign card_occupied_flag    = (state == ST_BUSY);      // [R23]
  assign transfer_request_flag = (state == ST_OUT) || (state == ST_IN);

  // error flag and error register; cleared by the next command
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      err_flag   <= 1'b0;
      error_code <= 8'h00;
    end else if (accept || soft_reset) begin
      err_flag   <= 1'b0;
      error_code <= 8'h00;
    end else if (state == ST_BUSY && busy_cnt == 8'h00) begin
      if (op == acd_pkg::OP_ABORT) begin
        err_flag   <= 1'b1;                                // [R27]
        error_code <= acd_pkg::ERR_ABORT;
      end else if (op == acd_pkg::OP_DIAG) begin
        error_code <= acd_pkg::DIAG_PASS;                  // [R2]
      end
    end
  end

  // interrupt request: a new event wins over a status read or accept clear; task-file reset wins over both
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      irq_pending <= 1'b0;
    else if (soft_reset)
      irq_pending <= 1'b0;
    else if ((state == ST_BUSY && busy_cnt == 8'h00 && op != acd_pkg::OP_FMT)
             || sec_end && op == acd_pkg::OP_RDMUL && secs_left == 9'h001)
      irq_pending <= 1'b1;                                 // [R16] [R18] [R21]
    else if (status_rd || accept)
      irq_pending <= 1'b0;
  end
  assign host_irq_line = irq_pending && !irq_mask_bit;    // [R24]

  // ----------------------------------------
  // settings and results
  // ----------------------------------------
  // effects of non-transfer commands, applied when the command is accepted
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      auto_pd_en        <= 1'b0;
      idle_mode         <= 1'b0;
      count_result      <= 8'h00;
      sectors_per_track <= acd_pkg::SPT_RST;
      heads_last        <= acd_pkg::HPC_RST;
      block_size        <= acd_pkg::BLK_RST;
    end else if (accept) begin
      unique case (next_op)
        acd_pkg::OP_PWR: count_result <= idle_mode ? acd_pkg::PWR_IDLE
                                                   : acd_pkg::PWR_ACTIVE; // [R1]
        acd_pkg::OP_IDLE: begin
          idle_mode <= 1'b1;                               // [R16] [R18]
          if (cmd_code == acd_pkg::CMD_IDLE_A || cmd_code == acd_pkg::CMD_IDLE_B)
            auto_pd_en <= (operands.count_operand != 8'h00); // [R17]
        end
        acd_pkg::OP_INIT: begin
          sectors_per_track <= operands.count_operand;     // [R19]
          heads_last        <= operands.head_operand;
        end
        acd_pkg::OP_SETMUL: block_size <= operands.count_operand; // [R26]
        default: count_result <= count_result;
      endcase
    end
  end

  // track fill request once the format sector has arrived
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fill_req <= '0;
    end else begin
      fill_req.fill <= buf_we && (idx == acd_pkg::WORDS_STD - 9'h001); // [R4]
      if (accept) begin
        fill_req.cyl     <= operands.cylinder_operand;
        fill_req.head    <= operands.head_operand;
        fill_req.pattern <= acd_pkg::FILL_PAT;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn || soft_reset);
  localparam int LIM = 8;

  sequence s_idle_taken;
    accept && next_op == acd_pkg::OP_IDLE;
  endsequence
  sequence s_busy_done;
    card_occupied_flag ##[1:LIM] (!card_occupied_flag && irq_pending);
  endsequence

  a_idle_irq_seq: assert property (s_idle_taken |=> s_busy_done) // [R16]
    else $error("idle did not end in ready with interrupt");
  a_busy_no_xfer: assert property (card_occupied_flag |-> !transfer_request_flag) // [R23]
    else $error("busy and data request together");
  a_mask_gates_irq: assert property (irq_mask_bit |-> !host_irq_line) // [R24]
    else $error("interrupt driven while masked");
  a_idle_pd_on: assert property (accept && cmd_code == acd_pkg::CMD_IDLE_A // [R17]
      && operands.count_operand != 8'h00 |=> auto_pd_en && idle_mode)
    else $error("auto power-down not enabled");
  a_abort_err: assert property (accept && next_op == acd_pkg::OP_ABORT // [R27]
      |-> ##[1:LIM] (err_flag && error_code == acd_pkg::ERR_ABORT))
    else $error("unknown command not aborted");
  a_diag_busy_long: assert property (accept && next_op == acd_pkg::OP_DIAG // [R2]
      |=> card_occupied_flag [*8])
    else $error("diagnostic ended too soon");
  a_id_word_zero: assert property (state == ST_OUT && op == acd_pkg::OP_ID // [R6]
      && idx == 9'h000 && !data_rd |=> data_out == acd_pkg::ID_W0)
    else $error("id word 0 wrong");
  a_id_word_caps: assert property (state == ST_OUT && op == acd_pkg::OP_ID // [R7]
      && idx == 9'h031 |=> data_out == acd_pkg::ID_W49)
    else $error("id word 49 wrong");
  a_long_len: assert property (state == ST_OUT && op == acd_pkg::OP_RDLONG // [R22]
      && data_rd && idx == 9'h101 |=> state == ST_READY)
    else $error("long read not 258 words");
  a_zero_count: assert property (accept && next_op == acd_pkg::OP_RDMUL // [R25]
      && operands.count_operand == 8'h00 |=> secs_left == 9'h100)
    else $error("zero count not 256 sectors");
  a_erase_keeps: assert property (op == acd_pkg::OP_NOP |-> !buf_we) // [R3]
    else $error("erase wrote the buffer");
  a_pwr_report: assert property (accept && next_op == acd_pkg::OP_PWR // [R1]
      |=> count_result == (idle_mode ? acd_pkg::PWR_IDLE : acd_pkg::PWR_ACTIVE))
    else $error("power state not reported");
endmodule // acd_decoder

// ---- bench/acd_host_model.sv ----
// acd_host_model: host task-file controller that drives the card decoder
`timescale 1ns/1ps
module acd_host_model (
  input  wire logic              mclk,
  input  wire logic              busy,
  input  wire logic              xfer_req,
  input  wire logic [15:0]       data_out,
  output logic                   soft_reset,
  output logic                   cmd_wr,
  output logic [7:0]             cmd_code,
  output acd_pkg::acd_operand_t  operands,
  output logic                   irq_mask_bit,
  output logic                   status_rd,
  output logic                   data_rd,
  output logic                   data_wr,
  output logic [15:0]            data_in
);
  logic [15:0] rbuf [0:257]; // words taken from the card
  int          nbusy;        // busy cycles of the last command
  // idle host, all strobes low
  initial begin
    {soft_reset, cmd_wr, irq_mask_bit, status_rd, data_rd, data_wr} = 6'h00;
    cmd_code = 8'h00;
    operands = '0;
    data_in = 16'hA5A5;
  end
  // command byte with operands, then busy counted until it drops
  task automatic issue(input logic [7:0] code, input logic [7:0] cnt,
                       input logic [3:0] head);
    @(negedge mclk);
    cmd_code = code;
    operands = '{count_operand: cnt, head_operand: head, cylinder_operand: 16'h0123,
                 default: '0};
    cmd_wr = 1'b1;
    @(negedge mclk);
    cmd_wr = 1'b0;
    nbusy = 0;
    for (int i = 0; i < 300; i++) begin
      if (busy) nbusy++;
      else if (nbusy > 0) break;
      @(negedge mclk);
    end
  endtask
  // word reads two cycles apart, waiting out busy gaps between blocks
  task automatic rd_words(input int n);
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 200 && xfer_req !== 1'b1; k++) @(negedge mclk);
      @(negedge mclk);
      data_rd = 1'b1;
      @(posedge mclk);
      if (i < 258) rbuf[i] = data_out;
      @(negedge mclk);
      data_rd = 1'b0;
    end
  endtask
  // one whole sector of words, back to back
  task automatic wr_words(input int n);
    for (int i = 0; i < n; i++) begin
      data_wr = 1'b1;
      data_in = 16'(i);
      @(negedge mclk);
    end
    data_wr = 1'b0;
    data_in = ~data_in;
  endtask
  // mask level, status read pulse, task-file reset pulse
  task automatic drive(input logic m, input logic s, input logic r);
    @(negedge mclk);
    irq_mask_bit = m;
    status_rd = s;
    soft_reset = r;
    @(negedge mclk);
    status_rd = 1'b0;
    soft_reset = 1'b0;
  endtask
endmodule // acd_host_model

// ---- bench/tb_ata_command_decoder.sv ----
// tb_ata_command_decoder: command sequences with expected results
`timescale 1ns/1ps
module tb_ata_command_decoder;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  logic                  mclk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  soft_reset, cmd_wr, irq_mask_bit, status_rd, data_rd, data_wr;
  logic [7:0]            cmd_code, error_code, count_result, sectors_per_track, block_size;
  logic [15:0]           data_in, data_out;
  logic                  busy, xfer_req, err_flag, host_irq_line, auto_pd_en, idle_mode, busy_q;
  logic [3:0]            heads_last;
  acd_pkg::acd_operand_t operands;
  acd_pkg::acd_fill_t    fill_req, fsave;
  int                    num_errors = 0;
  int                    samples_checked = 0;
  int                    nfill = 0;
  int                    nrise = 0;
  always #2 mclk = ~mclk;
  acd_decoder acd_decoder_inst (.mclk(mclk), .rstn(rstn), .soft_reset(soft_reset),
    .cmd_wr(cmd_wr), .cmd_code(cmd_code), .operands(operands), .irq_mask_bit(irq_mask_bit),
    .status_rd(status_rd), .data_rd(data_rd), .data_wr(data_wr), .data_in(data_in),
    .data_out(data_out), .card_occupied_flag(busy), .transfer_request_flag(xfer_req),
    .err_flag(err_flag), .error_code(error_code), .count_result(count_result),
    .host_irq_line(host_irq_line), .auto_pd_en(auto_pd_en), .idle_mode(idle_mode),
    .sectors_per_track(sectors_per_track), .heads_last(heads_last),
    .block_size(block_size), .fill_req(fill_req));
  acd_host_model acd_host_model_inst (.mclk(mclk), .busy(busy), .xfer_req(xfer_req),
    .data_out(data_out), .soft_reset(soft_reset), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .operands(operands), .irq_mask_bit(irq_mask_bit), .status_rd(status_rd),
    .data_rd(data_rd), .data_wr(data_wr), .data_in(data_in));
  // fill pulses and busy rises seen at the ports
  always @(posedge mclk) begin
    busy_q <= busy;
    if (busy === 1'b1 && busy_q === 1'b0) nrise++;
    if (fill_req.fill === 1'b1) begin
      nfill++;
      fsave = fill_req;
    end
  end
  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s over, mismatches so far %0d", name, num_errors);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well above the expected run of some five thousand cycles
  initial begin
    #240000;
    num_errors++;
    results();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    chk(sectors_per_track, acd_pkg::SPT_RST);
    chk(block_size, acd_pkg::BLK_RST);
    for (int i = 0; i < 2; i++) begin
      acd_host_model_inst.issue(i ? 8'h98 : 8'hE5, 8'h00, 4'h0);
      chk(acd_host_model_inst.nbusy, acd_pkg::BUSY_CYC);
      chk(count_result, acd_pkg::PWR_ACTIVE);
    end
    done("power");
    acd_host_model_inst.issue(8'hEC, 8'h00, 4'h0);
    chk(xfer_req, 1'b1);
    acd_host_model_inst.rd_words(256);
    @(negedge mclk);
    chk(xfer_req, 1'b0);
    chk(acd_host_model_inst.rbuf[0], acd_pkg::ID_W0);
    chk(acd_host_model_inst.rbuf[49], 16'h0E00);
    chk(acd_host_model_inst.rbuf[47], 16'h0001);
    chk(acd_host_model_inst.rbuf[64], 16'h0003);
    chk(acd_host_model_inst.rbuf[22], 16'h0004);
    chk(acd_host_model_inst.rbuf[51], 16'h0200);
    chk(acd_host_model_inst.rbuf[53], 16'h0003);
    chk(acd_host_model_inst.rbuf[59], 16'h0101);
    chk({acd_host_model_inst.rbuf[7], acd_host_model_inst.rbuf[8]}, acd_pkg::CARD_SECS);
    done("identify");
    acd_host_model_inst.issue(8'hE3, 8'hFF, 4'h0);
    chk({idle_mode, auto_pd_en, host_irq_line}, 3'b111);
    acd_host_model_inst.issue(8'h97, 8'h00, 4'h0);
    chk(auto_pd_en, 1'b0);
    acd_host_model_inst.issue(8'hE5, 8'h00, 4'h0);
    chk(count_result, acd_pkg::PWR_IDLE);
    acd_host_model_inst.issue(8'hE3, 8'h01, 4'h0);
    for (int i = 0; i < 2; i++) begin
      acd_host_model_inst.issue(i ? 8'h95 : 8'hE1, 8'h00, 4'h0);
      chk({acd_host_model_inst.nbusy[7:0], idle_mode, auto_pd_en, host_irq_line},
          {acd_pkg::BUSY_CYC, 3'b111});
    end
    acd_host_model_inst.drive(1'b1, 1'b0, 1'b0);
    chk(host_irq_line, 1'b0);
    acd_host_model_inst.drive(1'b0, 1'b0, 1'b0);
    chk(host_irq_line, 1'b1);
    acd_host_model_inst.drive(1'b0, 1'b1, 1'b0);
    chk(host_irq_line, 1'b0);
    done("idle");
    acd_host_model_inst.issue(8'h90, 8'h00, 4'h0);
    chk(acd_host_model_inst.nbusy, acd_pkg::DIAG_CYC);
    chk(error_code, acd_pkg::DIAG_PASS);
    acd_host_model_inst.issue(8'h91, 8'h3F, 4'h7);
    chk({sectors_per_track, heads_last}, 12'h3F7);
    acd_host_model_inst.issue(8'hC0, 8'h00, 4'h0);
    chk({err_flag, xfer_req, 8'(nfill)}, 10'h000);
    done("setup");
    acd_host_model_inst.issue(8'h50, 8'h01, 4'h5);
    chk(xfer_req, 1'b1);
    acd_host_model_inst.wr_words(256);
    repeat (12) @(negedge mclk);
    chk(nfill, 1);
    chk({fsave.cyl, fsave.head, fsave.pattern}, {16'h0123, 4'h5, acd_pkg::FILL_PAT});
    acd_host_model_inst.issue(8'hE4, 8'h00, 4'h0);
    acd_host_model_inst.rd_words(256);
    chk(acd_host_model_inst.rbuf[255], 16'h00FF);
    for (int i = 0; i < 2; i++) begin
      acd_host_model_inst.issue(i ? 8'h23 : 8'h22, 8'h00, 4'h0);
      acd_host_model_inst.rd_words(258);
      @(negedge mclk);
      chk({acd_host_model_inst.rbuf[256], acd_host_model_inst.rbuf[257]}, 32'h0);
      chk(xfer_req, 1'b0);
    end
    done("transfers");
    acd_host_model_inst.issue(8'hC6, 8'h02, 4'h0);
    chk(block_size, 8'h02);
    acd_host_model_inst.issue(8'hC4, 8'h03, 4'h0);
    nrise = 0;
    acd_host_model_inst.rd_words(768);
    repeat (12) @(negedge mclk);
    chk(nrise, 1);
    done("multiple");
    acd_host_model_inst.issue(8'hC4, 8'h00, 4'h0);
    acd_host_model_inst.rd_words(512);
    chk(busy, 1'b1);
    acd_host_model_inst.drive(1'b0, 1'b0, 1'b1);
    chk({xfer_req, busy}, 2'b00);
    acd_host_model_inst.issue(8'h00, 8'h00, 4'h0);
    chk({err_flag, error_code}, {1'b1, acd_pkg::ERR_ABORT});
    acd_host_model_inst.drive(1'b0, 1'b0, 1'b1);
    @(negedge mclk);
    chk({err_flag, busy}, 2'b00);
    done("abort");
    results();
  end
endmodule // tb_ata_command_decoder
